// *** adc_dev_model.sv ***
// Behavioural converter answering the host pins.
// Assumes pins settle long before edges; one conversion in flight.
`timescale 1ns/1ps
module adc_dev_model (
	input  wire        cs_n,
	input  wire        sh,
	input  wire        rd_n,
	input  wire        oe,
	input  wire        chan,
	input  wire        pd_n,
	output reg         eoc,
	output reg         int_n,
	output wire [11:0] bus,
	output integer     conv_count
);
	reg  [11:0] latch_q;
	reg  [11:0] last_q;
	reg         chan_q;
	wire        drive = oe && !cs_n && !rd_n;
	// Board straps: mode pin at ground, test pin at supply
	wire        mode_strap = 1'b0;
	wire        test_strap = 1'b1;
	// Released bus shows inverse of last value so stale data cannot pass
	assign bus = drive ? latch_q : ~last_q;
	always @* if (drive) last_q = latch_q;
	initial begin
		eoc = 1'b1;
		int_n = 1'b1;
		latch_q = 12'h000;
		last_q = 12'h000;
		conv_count = 0;
	end
	// Conversion, ignored in standby
	always @(negedge sh) begin
		if (!cs_n && pd_n && !mode_strap && test_strap) begin
			#90 eoc = 1'b0;
			chan_q = chan;
			// Codes chosen so neither equals the other's released-bus inverse
			#500 latch_q = chan_q ? 12'h3c6 : 12'h5a3;
			eoc = 1'b1;
			int_n = !rd_n;
			conv_count = conv_count + 1;
		end
	end
	// Read strobe clears the done flag
	always @(negedge rd_n) if (!cs_n) int_n = 1'b1;
endmodule // adc_dev_model

// *** adc_host_ctrl.v ***
// Host controller driving a clockless 12-bit two-input sampling converter.
// Assumes converter pins arrive asynchronously; the result bus is a plain input here.
`timescale 1ns/1ps
`include "adc_host_regs.vh"
module adc_host_ctrl (
	input  wire                 clk,
	input  wire                 rst_b,
	// User side
	input  wire                 start_req,
	input  wire                 start_chan,
	input  wire                 standby_req,
	input  wire                 stream_mode,
	output reg                  busy_ff,
	output reg                  result_valid_ff,
	output reg  [`RESULT_W-1:0] result_data_ff,
	output reg                  result_chan_ff,
	// Converter pins
	output reg                  device_select_n_ff,
	output reg                  sample_hold_strobe_ff,
	output reg                  read_strobe_n_ff,
	output reg                  output_drive_enable_ff,
	output reg                  input_channel_select_ff,
	output reg                  standby_request_n_ff,
	input  wire                 end_of_conversion,
	input  wire                 conversion_done_n,
	input  wire [`RESULT_W-1:0] result_bus
);
	localparam ST_IDLE  = 3'd0;
	localparam ST_SETUP = 3'd1;
	localparam ST_HOLD  = 3'd2;
	localparam ST_CONV  = 3'd3;
	localparam ST_READ  = 3'd4;
	localparam ST_WAKE  = 3'd5;
	localparam ST_SLEEP = 3'd6;

	// Counts kept as integers, cut to the counter width where loaded
	localparam integer CSS_I  = `CSS_CYC;
	localparam integer HOLD_I = `SH_LOW_CYC;
	localparam integer CONV_I = `EOC_WAIT_CYC + `MUX_HOLD_CYC;
	localparam integer READ_I = `ACC_CYC + 2;
	localparam integer WAKE_I = `WAKE_CYC;

	wire [1:0]           ctl_s;
	wire [`RESULT_W-1:0] data_s;
	wire                 eoc_s;
	wire                 done_n_s;

	reg  [2:0]           state_ff;
	reg  [2:0]           nxt_state;
	reg  [`CNT_W-1:0]    cnt_ff;
	reg  [`CNT_W-1:0]    nxt_cnt;
	reg                  eoc_seen_low_ff;
	reg                  nxt_eoc_seen_low;
	reg                  chan_ff;
	reg                  nxt_chan;
	reg                  stream_ff;
	reg                  nxt_stream;

	// Status pins and data resynchronised before any logic looks at them
	pin_sync #(.W(2)) u_ctl_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.async_in ({end_of_conversion, conversion_done_n}),
		.sync_out (ctl_s)
	);
	pin_sync #(.W(`RESULT_W)) u_data_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.async_in (result_bus),
		.sync_out (data_s)
	);
	assign eoc_s    = ctl_s[1];
	assign done_n_s = ctl_s[0];

	// Sequencer next state
	always @* begin
		nxt_state        = state_ff;
		nxt_cnt          = cnt_ff;
		nxt_eoc_seen_low = eoc_seen_low_ff;
		nxt_chan         = chan_ff;
		nxt_stream       = stream_ff;
		case (state_ff)
			ST_IDLE: begin
				if (!standby_req && !standby_request_n_ff) begin
					nxt_state = ST_WAKE;
					nxt_cnt   = WAKE_I[`CNT_W-1:0];
				end else if (standby_req) begin
					nxt_state = ST_SLEEP;
				end else if (start_req) begin
					nxt_chan   = start_chan;
					nxt_stream = stream_mode;
					nxt_state  = ST_SETUP;
					nxt_cnt    = CSS_I[`CNT_W-1:0];
				end
			end
			ST_SETUP: begin
				// Select settles before the strobe is allowed to move
				if (cnt_ff == {`CNT_W{1'b0}}) begin
					nxt_state = ST_HOLD;
					nxt_cnt   = HOLD_I[`CNT_W-1:0];
					nxt_eoc_seen_low = 1'b0;
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			ST_HOLD: begin
				if (cnt_ff == {`CNT_W{1'b0}}) begin
					nxt_state = ST_CONV;
					nxt_cnt   = CONV_I[`CNT_W-1:0];
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			ST_CONV: begin
				// Wait for the low phase of end_of_conversion, then its rise
				if (!eoc_s)
					nxt_eoc_seen_low = 1'b1;
				if (cnt_ff != {`CNT_W{1'b0}})
					nxt_cnt = cnt_ff - 1'b1;
				if (eoc_seen_low_ff && eoc_s && (stream_ff || !done_n_s)) begin
					nxt_state = ST_READ;
					nxt_cnt   = READ_I[`CNT_W-1:0];
				end
			end
			ST_READ: begin
				// Extra two cycles cover the data synchroniser latency
				if (cnt_ff == {`CNT_W{1'b0}})
					nxt_state = ST_IDLE;
				else
					nxt_cnt = cnt_ff - 1'b1;
			end
			ST_WAKE: begin
				// Wake-up time before the first strobe after standby
				if (cnt_ff == {`CNT_W{1'b0}})
					nxt_state = ST_IDLE;
				else
					nxt_cnt = cnt_ff - 1'b1;
			end
			ST_SLEEP: begin
				if (!standby_req) begin
					nxt_state = ST_WAKE;
					nxt_cnt   = WAKE_I[`CNT_W-1:0];
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Pin and status registers; all outputs come straight from flops
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff                <= ST_IDLE;
			cnt_ff                  <= {`CNT_W{1'b0}};
			eoc_seen_low_ff         <= 1'b0;
			chan_ff                 <= 1'b0;
			stream_ff               <= 1'b0;
			busy_ff                 <= 1'b0;
			result_valid_ff         <= 1'b0;
			result_data_ff          <= {`RESULT_W{1'b0}};
			result_chan_ff          <= 1'b0;
			device_select_n_ff      <= 1'b1;
			sample_hold_strobe_ff   <= 1'b1;
			read_strobe_n_ff        <= 1'b1;
			output_drive_enable_ff  <= 1'b0;
			input_channel_select_ff <= 1'b0;
			standby_request_n_ff    <= 1'b1;
		end else begin
			state_ff        <= nxt_state;
			cnt_ff          <= nxt_cnt;
			eoc_seen_low_ff <= nxt_eoc_seen_low;
			chan_ff         <= nxt_chan;
			stream_ff       <= nxt_stream;
			busy_ff         <= (nxt_state != ST_IDLE) && (nxt_state != ST_SLEEP);
			// Select low only around strobe and read activity
			device_select_n_ff <= !((nxt_state == ST_SETUP) || (nxt_state == ST_HOLD) ||
				(nxt_state == ST_CONV) || (nxt_state == ST_READ));
			// Strobe falls on entering hold; that edge starts the conversion
			sample_hold_strobe_ff <= (nxt_state != ST_HOLD);
			// Channel level stays put across the converter's start edge
			input_channel_select_ff <= nxt_chan;
			// Stream mode keeps read low through the conversion
			read_strobe_n_ff <= !((nxt_state == ST_READ) ||
				(nxt_stream && ((nxt_state == ST_HOLD) || (nxt_state == ST_CONV))));
			// Falling read edge clears the done flag on the device
			output_drive_enable_ff <= (nxt_state == ST_READ);
			standby_request_n_ff <= !(nxt_state == ST_SLEEP);
			// Capture on the last read cycle, after access time and sync delay
			result_valid_ff <= 1'b0;
			if (state_ff == ST_READ && cnt_ff == {`CNT_W{1'b0}}) begin
				result_valid_ff <= 1'b1;
				result_data_ff  <= data_s;
				result_chan_ff  <= chan_ff;
			end
		end
	end
	// Done flag is ignored in stream mode, as it stays high while read is low
	// Flag clearing and pipelining are the converter's own business
endmodule // adc_host_ctrl

// *** adc_host_ctrl_assertions.sv ***
// Checker on the host controller's converter pins.
// Assumes a bind onto adc_host_ctrl; one clock domain.
`timescale 1ns/1ps
module adc_host_ctrl_assertions (
	input wire clk,
	input wire rst_b,
	input wire busy_ff,
	input wire result_valid_ff,
	input wire device_select_n_ff,
	input wire sample_hold_strobe_ff,
	input wire read_strobe_n_ff,
	input wire output_drive_enable_ff,
	input wire input_channel_select_ff,
	input wire standby_request_n_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	strobe_needs_cs_a: assert property ($fell(sample_hold_strobe_ff) |-> !device_select_n_ff)
		else $error("strobe fell unselected");
	read_needs_cs_a: assert property (!read_strobe_n_ff |-> !device_select_n_ff)
		else $error("read low unselected");
	oe_needs_cs_a: assert property (output_drive_enable_ff |-> !device_select_n_ff)
		else $error("enable high unselected");
	chan_held_a: assert property (!device_select_n_ff && $past(!device_select_n_ff)
		|-> $stable(input_channel_select_ff))
		else $error("channel moved");
	cs_setup_a: assert property ($fell(device_select_n_ff) |-> sample_hold_strobe_ff[*6])
		else $error("select setup short");
	hold_len_a: assert property ($fell(sample_hold_strobe_ff) |-> (!sample_hold_strobe_ff)[*4] ##1 sample_hold_strobe_ff)
		else $error("strobe low length");
	standby_quiet_a: assert property (!standby_request_n_ff |-> sample_hold_strobe_ff && device_select_n_ff)
		else $error("activity in standby");
	valid_after_read_a: assert property (result_valid_ff |-> $past(!read_strobe_n_ff) && read_strobe_n_ff && !busy_ff)
		else $error("valid without read");
endmodule // adc_host_ctrl_assertions

// *** adc_host_regs.vh ***
// Constants for the sampling converter host controller.
// Assumes a 250 MHz clk; the converter has no clock and follows our pin edges.
`ifndef ADC_HOST_REGS_VH
`define ADC_HOST_REGS_VH
`define RESULT_W        12
`define CLK_PERIOD_PS   4000
`define CSS_NS          20
`define CSS_CYC         ((`CSS_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define SH_LOW_NS       10
`define SH_LOW_CYC      ((`SH_LOW_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define MUX_HOLD_NS     50
`define MUX_HOLD_CYC    ((`MUX_HOLD_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define ACC_NS          20
`define ACC_CYC         ((`ACC_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define EOC_WAIT_NS     126
`define EOC_WAIT_CYC    ((`EOC_WAIT_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define WAKE_NS         1000
`define WAKE_CYC        ((`WAKE_NS*1000+`CLK_PERIOD_PS-1)/`CLK_PERIOD_PS)
`define CNT_W           8
`endif

// *** pin_sync.v ***
// Two-flop synchroniser for the converter's output pins.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
module pin_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         rst_b,
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	// First stage feeds only the second; both reset to all ones (idle high)
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= {W{1'b1}};
			sync_ff <= {W{1'b1}};
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end
	assign sync_out = sync_ff;
endmodule // pin_sync

// *** test_adc_host_ctrl.sv ***
// Bench for the converter host controller with a behavioural converter.
// Assumes the model and checker files are compiled first.
`timescale 1ns/1ps
`include "adc_host_regs.vh"
module test_adc_host_ctrl;
	reg         clk, rst_b, start_req, start_chan, standby_req, stream_mode;
	wire        busy, valid, chan_o, cs_n, sh, rd_n, oe, chan, pd_n, eoc, int_n;
	wire [11:0] data, bus;
	integer     bad_count, cmp_count, n_conv, i;
	adc_host_ctrl i_adc_host_ctrl (.clk(clk), .rst_b(rst_b), .start_req(start_req), .start_chan(start_chan),
		.standby_req(standby_req), .stream_mode(stream_mode), .busy_ff(busy), .result_valid_ff(valid),
		.result_data_ff(data), .result_chan_ff(chan_o), .device_select_n_ff(cs_n), .sample_hold_strobe_ff(sh),
		.read_strobe_n_ff(rd_n), .output_drive_enable_ff(oe), .input_channel_select_ff(chan),
		.standby_request_n_ff(pd_n), .end_of_conversion(eoc), .conversion_done_n(int_n), .result_bus(bus));
	adc_dev_model i_adc_dev_model (.cs_n(cs_n), .sh(sh), .rd_n(rd_n), .oe(oe), .chan(chan), .pd_n(pd_n),
		.eoc(eoc), .int_n(int_n), .bus(bus), .conv_count(n_conv));
	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task check(input [11:0] got, input [11:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("ERROR at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("Compares %0d mismatches %0d", cmp_count, bad_count);
			if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
			else $display("Simulation failed");
			$finish;
		end
	endtask
	// Bounded wait for a flag to reach a level
	task wait_for(input which, input lvl);
		begin
			for (i = 0; ((which ? busy : valid) !== lvl) && i < 1000; i = i + 1) @(posedge clk) #1;
			if (i == 1000) begin
				bad_count = bad_count + 1;
				tally_and_finish;
			end
		end
	endtask
	task do_conv(input c, input s, input [11:0] exp);
		begin
			start_req = 1'b1;
			start_chan = c;
			stream_mode = s;
			@(posedge clk) #1 start_req = 1'b0;
			wait_for(1'b0, 1'b1);
			check(data, exp);
			check({11'h000, chan_o}, {11'h000, c});
			check({11'h000, int_n}, 12'h001);
			@(posedge clk) #1;
		end
	endtask
	task scen_interrupt;
		begin
			do_conv(1'b0, 1'b0, 12'h5a3);
			do_conv(1'b1, 1'b0, 12'h3c6);
		end
	endtask
	task scen_stream;
		do_conv(1'b0, 1'b1, 12'h5a3);
	endtask
	task scen_standby;
		begin
			standby_req = 1'b1;
			repeat (2) @(posedge clk) #1;
			check({11'h000, pd_n}, 12'h000);
			start_req = 1'b1;
			repeat (4) @(posedge clk) #1;
			check({11'h000, busy}, 12'h000);
			check(n_conv[11:0], 12'h003);
			start_req = 1'b0;
			standby_req = 1'b0;
			repeat (3) @(posedge clk) #1;
			wait_for(1'b1, 1'b0);
			check({11'h000, pd_n}, 12'h001);
			do_conv(1'b1, 1'b0, 12'h3c6);
		end
	endtask
	// Reset, then scenarios
	initial begin
		{rst_b, start_req, start_chan, standby_req, stream_mode} = 5'h00;
		bad_count = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk);
		#1 rst_b = 1'b1;
		scen_interrupt;
		scen_stream;
		scen_standby;
		tally_and_finish;
	end
endmodule // test_adc_host_ctrl
bind adc_host_ctrl adc_host_ctrl_assertions i_adc_host_ctrl_assertions (.clk(clk), .rst_b(rst_b),
	.busy_ff(busy_ff), .result_valid_ff(result_valid_ff), .device_select_n_ff(device_select_n_ff),
	.sample_hold_strobe_ff(sample_hold_strobe_ff), .read_strobe_n_ff(read_strobe_n_ff),
	.output_drive_enable_ff(output_drive_enable_ff), .input_channel_select_ff(input_channel_select_ff),
	.standby_request_n_ff(standby_request_n_ff));
